// ### celog_top.sv
// Cache error detection, recovery control and logging
// Operation
// - Load ECC error on data cache records address bits 19:6, keeps 42:20.
// - Corrected load error sets load flag, retries load, rewrites register, posts irq.
// - Speculative load error sets load flag and posts irq; no retry, status zero, no address.
// - Small store ECC error scrubs quadword, replays write, sets store flag, irq.
// - Data cache victim errors corrected into victim buffer silently.
// - Second close store error: no correction, store and second flags, machine check.
// - Duplicate tag parity checked only during eight-location physical tag reads.
// - Duplicate tag parity error sets flag, logs address 42:6, machine check.
// - Board tag parity checked on every reference except invalid blocks in valid-only mode; flag, address, machine check.
// - Valid-only mode computes board parity for valid blocks; otherwise all blocks.
// - Instruction fill board error poisons octaword parity, flushes, sets flag.
// - Instruction fill board error logs address, syndromes, machine check and irq.
// - Unconsumed bad fill quadword written unchanged; status logged, irq posted.
// - Consumed bad fill: no raw write signalled, entry kept, replay stalled at map.
// - Error-read request scrubs block via victim buffer; logs flag, address, syndromes.
// - Board victim error sent uncorrected; irq posted, error register unchanged.
// - Victim error on combined miss: load flag set, status zero, irq posted.
// - Board victim during evict-block goes uncorrected, no logging, no exception.
// - Instruction fill memory error poisons parity, flushes, sets flag, logs all.
`timescale 1ns/100ps
`include "celog_defines.svh"
module celog_top
  import celog_pkg::*;
#(
  // Duplicate tag locations covered by one physical read
  parameter int unsigned DUP_LOCS = 8
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Configuration
  input wire logic parity_valid_only_mode_i,
  input wire logic crd_enable_i,
  input wire logic machine_check_enable_i,
  input wire logic privileged_mode_i,
  input wire logic evict_block_instr_i,
  // Data cache load and store error events
  input wire logic ld_ecc_err_i,
  input wire logic ld_speculative_i,
  input wire logic [36:0] ld_addr_i,
  input wire logic st_ecc_err_i,
  input wire logic dc_victim_err_i,
  // Tag parity events
  input wire logic dup_tag_phys_read_i,
  input wire logic [DUP_LOCS-1:0] dup_tag_par_bad_i,
  input wire logic [36:0] dup_tag_addr_i,
  input wire logic board_tag_ref_i,
  input wire logic board_tag_valid_i,
  input wire logic board_tag_par_bad_i,
  input wire logic [36:0] board_tag_addr_i,
  // Fill and victim data errors
  input wire logic ifill_board_err_i,
  input wire logic ifill_mem_err_i,
  input wire logic dfill_board_err_i,
  input wire logic dfill_consumed_i,
  input wire logic read_err_req_i,
  input wire logic board_victim_err_i,
  input wire logic combined_miss_i,
  input wire celog_err_info_t fill_info_i,
  // Software clear
  input wire logic status_clear_i,
  // Recovery actions
  output logic ld_retry_o,
  output logic st_scrub_replay_o,
  output logic victim_correct_o,
  output logic fill_write_raw_o,
  output logic map_stall_o,
  output logic scrub_evict_o,
  output logic icache_flush_o,
  output logic ipar_poison_o,
  output logic victim_uncorrected_o,
  // Status
  output logic load_ecc_flag_o,
  output logic store_ecc_flag_o,
  output logic second_error_flag_o,
  output logic dup_tag_parity_flag_o,
  output logic board_tag_parity_flag_o,
  output logic ifetch_board_fill_flag_o,
  output logic ifetch_mem_fill_flag_o,
  output logic dfetch_board_fill_flag_o,
  output logic [3:0] cstat_o,
  output celog_err_info_t err_info_o,
  // Exceptions
  output logic corrected_read_data_irq_o,
  output logic machine_check_o
);

  // ---------------------------------------------------------------
  // Duplicate tag parity, one check per location read
  // ---------------------------------------------------------------
  logic [DUP_LOCS-1:0] dup_loc_err;

  for (genvar i = 0; i < DUP_LOCS; i++) begin : g_dup_loc
    assign dup_loc_err[i] = dup_tag_phys_read_i && dup_tag_par_bad_i[i];
  end

  // ---------------------------------------------------------------
  // Event qualification
  // ---------------------------------------------------------------
  logic dup_perr;
  logic board_perr;
  logic ld_real;
  logic st_first;
  logic st_second;
  logic dfill_quiet;
  logic dfill_load;
  logic victim_log_crd;
  logic log_evt;
  logic [2:0] st_win_q;
  celog_state_t state_q;

  assign dup_perr = |dup_loc_err;
  // Invalid blocks carry no parity in valid-only mode
  assign board_perr = board_tag_ref_i && board_tag_par_bad_i &&
                      (!parity_valid_only_mode_i || board_tag_valid_i);
  assign ld_real = ld_ecc_err_i && !ld_speculative_i;
  assign st_second = st_ecc_err_i && (st_win_q != 3'h0);
  assign st_first = st_ecc_err_i && !st_second;
  assign dfill_quiet = dfill_board_err_i && !dfill_consumed_i;
  assign dfill_load = dfill_board_err_i && dfill_consumed_i;
  assign victim_log_crd = board_victim_err_i && !evict_block_instr_i;
  // Anything that writes the cache controller error status
  assign log_evt = dup_perr || board_perr || ifill_board_err_i || ifill_mem_err_i ||
                   (state_q == CELOG_SCRUB) || dfill_quiet || ld_real;

  // ---------------------------------------------------------------
  // Store second-error window
  // ---------------------------------------------------------------
  // A first error opens the window; store errors inside it are second errors
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_win_q <= 3'h0;
    end else if (st_first) begin
      st_win_q <= 3'(`CELOG_SECOND_WIN);
    end else if (st_win_q != 3'h0) begin
      st_win_q <= st_win_q - 3'h1;
    end
  end

  // ---------------------------------------------------------------
  // Recovery actions
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ld_retry_o <= 1'b0;
      st_scrub_replay_o <= 1'b0;
      victim_correct_o <= 1'b0;
    end else begin
      ld_retry_o <= ld_real || (state_q == CELOG_SCRUB);
      st_scrub_replay_o <= st_first;
      victim_correct_o <= dc_victim_err_i;
    end
  end

  // ---------------------------------------------------------------
  // Fill and victim recovery actions
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      fill_write_raw_o <= 1'b0;
      icache_flush_o <= 1'b0;
      ipar_poison_o <= 1'b0;
      victim_uncorrected_o <= 1'b0;
    end else begin
      fill_write_raw_o <= dfill_quiet;
      icache_flush_o <= ifill_board_err_i || ifill_mem_err_i;
      ipar_poison_o <= ifill_board_err_i || ifill_mem_err_i;
      victim_uncorrected_o <= board_victim_err_i;
    end
  end

  // ---------------------------------------------------------------
  // Consumed fill error: stall, error-read scrub, retry
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_q <= CELOG_IDLE;
    end else begin
      case (state_q)
        CELOG_IDLE: begin
          if (dfill_load) begin
            state_q <= CELOG_HOLD;
          end
        end
        CELOG_HOLD: begin
          if (read_err_req_i) begin
            state_q <= CELOG_SCRUB;
          end
        end
        CELOG_SCRUB: begin
          state_q <= CELOG_IDLE;
        end
        default: begin
          state_q <= CELOG_IDLE;
        end
      endcase
    end
  end

  assign map_stall_o = (state_q != CELOG_IDLE);
  assign scrub_evict_o = (state_q == CELOG_SCRUB);

  // ---------------------------------------------------------------
  // Data cache status flags
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      load_ecc_flag_o <= 1'b0;
      store_ecc_flag_o <= 1'b0;
      second_error_flag_o <= 1'b0;
    end else begin
      // Set wins over a simultaneous clear
      if (ld_ecc_err_i || (state_q == CELOG_SCRUB) ||
          (board_victim_err_i && combined_miss_i && !evict_block_instr_i)) begin
        load_ecc_flag_o <= 1'b1;
      end else if (status_clear_i) begin
        load_ecc_flag_o <= 1'b0;
      end
      if (st_ecc_err_i) begin
        store_ecc_flag_o <= 1'b1;
      end else if (status_clear_i) begin
        store_ecc_flag_o <= 1'b0;
      end
      if (st_second) begin
        second_error_flag_o <= 1'b1;
      end else if (status_clear_i) begin
        second_error_flag_o <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Cache controller status, address and syndromes
  // ---------------------------------------------------------------
  logic cstat_busy;
  assign cstat_busy = (cstat_o != `CELOG_CSTAT_NONE);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      dup_tag_parity_flag_o <= 1'b0;
      board_tag_parity_flag_o <= 1'b0;
      ifetch_board_fill_flag_o <= 1'b0;
      ifetch_mem_fill_flag_o <= 1'b0;
      dfetch_board_fill_flag_o <= 1'b0;
      cstat_o <= `CELOG_CSTAT_NONE;
      err_info_o <= '0;
    end else begin
      // A new error wins over a clear in the same cycle
      if (dup_perr) begin
        dup_tag_parity_flag_o <= 1'b1;
      end else if (status_clear_i) begin
        dup_tag_parity_flag_o <= 1'b0;
      end
      if (board_perr) begin
        board_tag_parity_flag_o <= 1'b1;
      end else if (status_clear_i) begin
        board_tag_parity_flag_o <= 1'b0;
      end
      if (ifill_board_err_i) begin
        ifetch_board_fill_flag_o <= 1'b1;
      end else if (status_clear_i) begin
        ifetch_board_fill_flag_o <= 1'b0;
      end
      if (ifill_mem_err_i) begin
        ifetch_mem_fill_flag_o <= 1'b1;
      end else if (status_clear_i) begin
        ifetch_mem_fill_flag_o <= 1'b0;
      end
      if ((state_q == CELOG_SCRUB) || dfill_quiet) begin
        dfetch_board_fill_flag_o <= 1'b1;
      end else if (status_clear_i) begin
        dfetch_board_fill_flag_o <= 1'b0;
      end
      // First captured error keeps the address until software clears
      if (log_evt && (!cstat_busy || status_clear_i)) begin
        if (dup_perr) begin
          cstat_o <= `CELOG_CSTAT_DUP_PERR;
          err_info_o.addr <= dup_tag_addr_i;
        end else if (board_perr) begin
          cstat_o <= `CELOG_CSTAT_BOARD_TAG_PARITY_FLAG;
          err_info_o.addr <= board_tag_addr_i;
        end else if (ifill_board_err_i || ifill_mem_err_i) begin
          cstat_o <= ifill_board_err_i ? `CELOG_CSTAT_IBC_ERR : `CELOG_CSTAT_IMEM_ERR;
          err_info_o <= fill_info_i;
        end else if ((state_q == CELOG_SCRUB) || dfill_quiet) begin
          cstat_o <= `CELOG_CSTAT_DBC_ERR;
          err_info_o <= fill_info_i;
        end else begin
          cstat_o <= `CELOG_CSTAT_DC_ERR;
          err_info_o.addr[13:0] <= ld_addr_i[13:0];
        end
      end else if (status_clear_i) begin
        cstat_o <= `CELOG_CSTAT_NONE;
      end
    end
  end

  // ---------------------------------------------------------------
  // Exceptions
  // ---------------------------------------------------------------
  logic crd_evt;
  logic machine_check_defer;
  logic machine_check_now;
  logic machine_check_pend_q;

  assign crd_evt = ld_ecc_err_i || st_first || ifill_board_err_i || ifill_mem_err_i ||
                   dfill_quiet || (state_q == CELOG_SCRUB) || victim_log_crd;
  assign machine_check_defer = st_second || dup_perr || board_perr;
  assign machine_check_now = ifill_board_err_i || ifill_mem_err_i;

  // Posted even where nothing is logged or corrected
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      corrected_read_data_irq_o <= 1'b0;
    end else if (crd_evt && crd_enable_i) begin
      corrected_read_data_irq_o <= 1'b1;
    end else if (status_clear_i) begin
      corrected_read_data_irq_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      machine_check_pend_q <= 1'b0;
    end else if (machine_check_defer && machine_check_enable_i) begin
      machine_check_pend_q <= 1'b1;
    end else if (status_clear_i || machine_check_o) begin
      machine_check_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      machine_check_o <= 1'b0;
    end else begin
      // Deferred checks wait for native mode; instruction fill errors are immediate
      machine_check_o <= machine_check_now ||
                         (machine_check_pend_q && !privileged_mode_i && !machine_check_o);
    end
  end

endmodule // celog_top

// ### celog_defines.svh
// Constants for the cache error logger
`ifndef CELOG_DEFINES_SVH
`define CELOG_DEFINES_SVH
`define CELOG_ADDR_MSB 42
`define CELOG_ADDR_LSB 6
`define CELOG_DC_ADDR_MSB 19
`define CELOG_SYN_W 8
`define CELOG_CSTAT_W 4
`define CELOG_CSTAT_NONE 4'h0
`define CELOG_CSTAT_DC_ERR 4'h1
`define CELOG_CSTAT_DUP_PERR 4'h2
`define CELOG_CSTAT_BOARD_TAG_PARITY_FLAG 4'h3
`define CELOG_CSTAT_IBC_ERR 4'h4
`define CELOG_CSTAT_DBC_ERR 4'h5
`define CELOG_CSTAT_IMEM_ERR 4'h6
`define CELOG_CSTAT_DMEM_ERR 4'h7
`define CELOG_SECOND_WIN 4
`endif

// ### celog_pkg.sv
// Types for the cache error logger
package celog_pkg;
  typedef struct packed {
    logic [36:0] addr;
    logic [7:0] syn0;
    logic [7:0] syn1;
  } celog_err_info_t;
  typedef enum logic [2:0] {
    CELOG_IDLE = 3'b001,
    CELOG_SCRUB = 3'b010,
    CELOG_HOLD = 3'b100
  } celog_state_t;
endpackage

// ### celog_pipe_model.sv
// Pipeline and firmware partner of the cache error logger
`timescale 1ns/100ps
module celog_pipe_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Stall and knobs
  input wire logic map_stall_i,
  input wire logic [3:0] lag_i,
  input wire logic [5:0] tag_msb_i,
  input wire logic [5:0] max_pa_i,
  // To the logger
  output logic read_err_req_o,
  output logic valid_mode_o
);
  logic [3:0] wait_q;
  assign valid_mode_o = tag_msb_i < max_pa_i;
  // Error-read request lag_i+1 cycles into the replay stall
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !map_stall_i) begin
      wait_q <= 4'h0;
      read_err_req_o <= 1'b0;
    end else begin
      wait_q <= wait_q + 4'h1;
      read_err_req_o <= wait_q == lag_i;
    end
  end
endmodule // celog_pipe_model

// ### celog_sva.sv
// Assertions on the cache error logger ports
`timescale 1ns/100ps
module celog_sva
  import celog_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Inputs
  input wire logic parity_valid_only_mode_i,
  input wire logic ld_ecc_err_i,
  input wire logic ld_speculative_i,
  input wire logic st_ecc_err_i,
  input wire logic dc_victim_err_i,
  input wire logic dup_tag_phys_read_i,
  input wire logic [7:0] dup_tag_par_bad_i,
  input wire logic board_tag_ref_i,
  input wire logic board_tag_valid_i,
  input wire logic board_tag_par_bad_i,
  input wire logic ifill_board_err_i,
  input wire logic read_err_req_i,
  input wire logic status_clear_i,
  // Outputs
  input wire logic ld_retry_o,
  input wire logic victim_correct_o,
  input wire logic map_stall_o,
  input wire logic scrub_evict_o,
  input wire logic icache_flush_o,
  input wire logic store_ecc_flag_o,
  input wire logic second_error_flag_o,
  input wire logic dup_tag_parity_flag_o,
  input wire logic board_tag_parity_flag_o,
  input wire logic [3:0] cstat_o,
  input wire celog_err_info_t err_info_o,
  input wire logic machine_check_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  AST_LD_RETRY: assert property (ld_ecc_err_i && !ld_speculative_i |=> ld_retry_o)
    else $error("load not retried");
  AST_ST_FLAG: assert property (st_ecc_err_i |=> store_ecc_flag_o)
    else $error("store flag missing");
  AST_SECOND: assert property (st_ecc_err_i ##[1:3] st_ecc_err_i |=> second_error_flag_o)
    else $error("second error missed");
  AST_DC_VICTIM: assert property (dc_victim_err_i |=> victim_correct_o)
    else $error("victim not corrected");
  AST_DUP_GATE: assert property ($rose(dup_tag_parity_flag_o) |-> $past(dup_tag_phys_read_i))
    else $error("dup parity outside read");
  AST_DUP_FLAG:
    assert property (dup_tag_phys_read_i && (|dup_tag_par_bad_i) |=> dup_tag_parity_flag_o)
    else $error("dup parity flag missing");
  AST_BOARD_TAG:
    assert property (board_tag_ref_i && board_tag_par_bad_i &&
      (board_tag_valid_i || !parity_valid_only_mode_i) |=> board_tag_parity_flag_o)
    else $error("board parity flag missing");
  AST_IFILL:
    assert property (ifill_board_err_i |=> icache_flush_o && machine_check_o)
    else $error("ifill recovery missing");
  AST_SCRUB:
    assert property (map_stall_o && !scrub_evict_o && read_err_req_i |=>
      scrub_evict_o ##1 (ld_retry_o && !map_stall_o))
    else $error("scrub sequence wrong");
  AST_HOLD:
    assert property (cstat_o != 4'h0 && !status_clear_i |=> $stable(cstat_o) && $stable(err_info_o))
    else $error("status overwritten");
  COV_SECOND: cover property (st_ecc_err_i ##[1:3] st_ecc_err_i);
  COV_SCRUB: cover property (scrub_evict_o);
  COV_VALID: cover property (board_tag_ref_i && parity_valid_only_mode_i && !board_tag_valid_i);
endmodule // celog_sva
bind celog_top celog_sva u_sva (.*);

// ### tb_cache_ecc_error_logger.sv
// Self-checking bench for the cache error logger
`timescale 1ns/100ps
module tb_cache_ecc_error_logger;
  import celog_pkg::*;
  logic clk_i, sys_rst_i = 1'b1, parity_valid_only_mode_i, read_err_req_i, m;
  logic crd_enable_i = 1'b1, machine_check_enable_i = 1'b1, privileged_mode_i = 1'b0;
  logic evict_block_instr_i = 1'b0, ld_ecc_err_i = 1'b0, ld_speculative_i = 1'b0;
  logic st_ecc_err_i = 1'b0, dc_victim_err_i = 1'b0, dup_tag_phys_read_i = 1'b0;
  logic board_tag_ref_i = 1'b0, board_tag_valid_i = 1'b0, board_tag_par_bad_i = 1'b0;
  logic ifill_board_err_i = 1'b0, ifill_mem_err_i = 1'b0, dfill_board_err_i = 1'b0;
  logic dfill_consumed_i = 1'b0, board_victim_err_i = 1'b0, combined_miss_i = 1'b0;
  logic status_clear_i = 1'b0;
  logic [7:0] dup_tag_par_bad_i = 8'h00;
  logic [36:0] ld_addr_i = '0, dup_tag_addr_i = '0, board_tag_addr_i = '0, a;
  logic [5:0] tag_msb = 6'h00, max_pa = 6'h24;
  logic [3:0] lag = 4'h0, cstat_o;
  celog_err_info_t fill_info_i = '0, fi, err_info_o;
  logic ld_retry_o, st_scrub_replay_o, victim_correct_o, fill_write_raw_o, map_stall_o;
  logic scrub_evict_o, icache_flush_o, ipar_poison_o, victim_uncorrected_o, load_ecc_flag_o;
  logic store_ecc_flag_o, second_error_flag_o, dup_tag_parity_flag_o, board_tag_parity_flag_o;
  logic ifetch_board_fill_flag_o, ifetch_mem_fill_flag_o, dfetch_board_fill_flag_o;
  logic corrected_read_data_irq_o, machine_check_o;
  int n_errors = 0, n_checks = 0, cyc = 0, k;
  celog_top dut (.*);
  celog_pipe_model pm (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .map_stall_i(map_stall_o),
    .lag_i(lag), .tag_msb_i(tag_msb), .max_pa_i(max_pa), .read_err_req_o(read_err_req_i),
    .valid_mode_o(parity_valid_only_mode_i));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic tally_and_finish;
    if (n_errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic fire(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic bpar(input logic mv, input logic v);
    return !mv || v;
  endfunction
  initial begin
    void'($urandom(60));
    step(5);
    sys_rst_i = 1'b0;
    step(1);
    chk({cstat_o, err_info_o}, '0);
    for (k = 0; k < 2; k++) begin
      fi = celog_err_info_t'({$urandom(), $urandom()});
      fill_info_i = fi;
      ifill_board_err_i = k == 0;
      ifill_mem_err_i = k == 1;
      step(1);
      ifill_board_err_i = 1'b0;
      ifill_mem_err_i = 1'b0;
      chk({icache_flush_o, ipar_poison_o, corrected_read_data_irq_o}, 3'h7);
      chk({ifetch_board_fill_flag_o, ifetch_mem_fill_flag_o}, k ? 2'h1 : 2'h2);
      chk({cstat_o, err_info_o}, {4'(4 + 2 * k), fi});
      if (k == 0) chk(machine_check_o, 1'b1);
      fill_info_i = ~fi;
      fire(ifill_board_err_i);
      chk({cstat_o, err_info_o}, {4'(4 + 2 * k), fi});
      fire(status_clear_i);
    end
    a = 37'({$urandom(), $urandom()});
    ld_addr_i = a;
    fire(ld_ecc_err_i);
    chk({ld_retry_o, load_ecc_flag_o, corrected_read_data_irq_o, cstat_o}, 7'h71);
    chk(err_info_o.addr, {fi.addr[36:14], a[13:0]});
    fire(status_clear_i);
    ld_speculative_i = 1'b1;
    fire(ld_ecc_err_i);
    ld_speculative_i = 1'b0;
    chk({cstat_o, corrected_read_data_irq_o, err_info_o.addr}, {5'h01, fi.addr[36:14], a[13:0]});
    fire(status_clear_i);
    for (k = 0; k < 2; k++) begin
      privileged_mode_i = k[0];
      fire(st_ecc_err_i);
      chk({st_scrub_replay_o, store_ecc_flag_o, second_error_flag_o}, 3'h6);
      step(1);
      fire(st_ecc_err_i);
      chk({st_scrub_replay_o, second_error_flag_o}, 2'h1);
      step(1);
      chk(machine_check_o, !k[0]);
      fire(status_clear_i);
      step(5);
    end
    privileged_mode_i = 1'b0;
    fire(dc_victim_err_i);
    chk({victim_correct_o, cstat_o, corrected_read_data_irq_o}, 6'h20);
    crd_enable_i = 1'b0;
    fire(st_ecc_err_i);
    chk({store_ecc_flag_o, corrected_read_data_irq_o}, 2'h2);
    crd_enable_i = 1'b1;
    fire(status_clear_i);
    for (k = 0; k < 2; k++) begin
      a = 37'({$urandom(), $urandom()});
      dup_tag_addr_i = a;
      dup_tag_par_bad_i = 8'h01 << ($urandom() % 8);
      dup_tag_phys_read_i = k[0];
      step(1);
      dup_tag_phys_read_i = 1'b0;
      chk(dup_tag_parity_flag_o, k[0]);
      if (k[0]) chk({cstat_o, err_info_o.addr}, {4'h2, a});
      step(1);
      chk(machine_check_o, k[0]);
      fire(status_clear_i);
      dup_tag_par_bad_i = 8'h00;
    end
    board_tag_par_bad_i = 1'b1;
    for (k = 0; k < 4; k++) begin
      tag_msb = k[1] ? 6'(36 + $urandom() % 8) : 6'($urandom() % 36);
      m = !k[1];
      a = 37'({$urandom(), $urandom()});
      board_tag_addr_i = a;
      board_tag_valid_i = k[0];
      machine_check_enable_i = !k[0];
      fire(board_tag_ref_i);
      chk(parity_valid_only_mode_i, m);
      chk(board_tag_parity_flag_o, bpar(m, k[0]));
      if (bpar(m, k[0])) chk({cstat_o, err_info_o.addr}, {4'h3, a});
      step(1);
      chk(machine_check_o, bpar(m, k[0]) && !k[0]);
      fire(status_clear_i);
      machine_check_enable_i = 1'b1;
    end
    fi = celog_err_info_t'({$urandom(), $urandom()});
    fill_info_i = fi;
    fire(dfill_board_err_i);
    chk({fill_write_raw_o, map_stall_o, corrected_read_data_irq_o, cstat_o}, 7'h55);
    chk(err_info_o, fi);
    fire(status_clear_i);
    lag = 4'($urandom() % 10);
    dfill_consumed_i = 1'b1;
    fire(dfill_board_err_i);
    dfill_consumed_i = 1'b0;
    chk({map_stall_o, fill_write_raw_o, ld_retry_o}, 3'h4);
    for (k = 0; k < 20 && scrub_evict_o !== 1'b1; k++) step(1);
    chk(scrub_evict_o, 1'b1);
    step(1);
    chk({ld_retry_o, load_ecc_flag_o, dfetch_board_fill_flag_o, map_stall_o}, 4'he);
    chk({cstat_o, err_info_o}, {4'h5, fi});
    fire(status_clear_i);
    for (k = 0; k < 3; k++) begin
      combined_miss_i = k == 1;
      evict_block_instr_i = k == 2;
      fire(board_victim_err_i);
      chk({victim_uncorrected_o, cstat_o, corrected_read_data_irq_o, err_info_o},
        {5'h10, k != 2, fi});
      fire(status_clear_i);
    end
    fire(st_ecc_err_i);
    sys_rst_i = 1'b1;
    step(2);
    sys_rst_i = 1'b0;
    step(1);
    chk({store_ecc_flag_o, corrected_read_data_irq_o, cstat_o}, 6'h00);
    tally_and_finish();
  end
endmodule // tb_cache_ecc_error_logger
